// ===== mcuix_pkg.sv
// Purpose: shared constants for the instruction execute subset
// Assumes: 8-bit data path, 14-bit program words, 11-bit program addresses
// Notes: opcode selector codes are local to this block
package mcuix_pkg;
   localparam int DATA_W = 8;
   localparam int PROG_W = 14;
   localparam int PADDR_W = 11;
   localparam int BIT_SEL_W = 3;
   localparam int NIB_W = 4;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam int FLAG_C = 0;
   localparam int FLAG_AC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   typedef enum logic [4:0] {
      MCUIX_OP_NONE,
      MCUIX_OP_BIT_SET,
      MCUIX_OP_INC_SKIP_ZERO,
      MCUIX_OP_INC_TO_WORK_SKIP_NULL,
      MCUIX_OP_SKIP_IF_BIT_SET,
      MCUIX_OP_MINUS_TO_WORK,
      MCUIX_OP_MINUS_TO_MEMORY,
      MCUIX_OP_MINUS_IMM,
      MCUIX_OP_NIBBLE_EXCHANGE,
      MCUIX_OP_NIBBLE_EXCHANGE_TO_WORK,
      MCUIX_OP_SKIP_IF_NULL,
      MCUIX_OP_COPY_THEN_SKIP_NULL,
      MCUIX_OP_SKIP_IF_BIT_CLEAR,
      MCUIX_OP_TABLE_READ_CURRENT_PAGE,
      MCUIX_OP_TABLE_READ_LAST_PAGE,
      MCUIX_OP_XOR_TO_WORK,
      MCUIX_OP_EXCLUSIVE_OR_TO_MEMORY,
      MCUIX_OP_XOR_IMM
   } mcuix_op_type;
   localparam logic [4:0] MCUIX_OP_XOR_IMM_CODE = 5'h11;
endpackage : mcuix_pkg

// ===== mcuix_sub.sv
// Purpose: 8-bit subtractor producing result and four status flags
// Assumes: minuend minus subtrahend, no borrow in
// Notes: carry is set when no borrow occurs
`timescale 1ns/100ps
module mcuix_sub #(
   parameter int W = 8
)
(
   input wire logic [W-1:0] a_in,
   input wire logic [W-1:0] b_in,
   output logic [W-1:0] diff_out,
   output logic carry_out,
   output logic half_carry_out,
   output logic wrap_out,
   output logic zero_out
);
   logic [W:0] full;
   logic [W/2:0] low;
   always_comb
   begin
      full = {1'b0, a_in} + {1'b0, ~b_in} + {{W{1'b0}}, 1'b1};
      low = {1'b0, a_in[W/2-1:0]} + {1'b0, ~b_in[W/2-1:0]} + {{(W/2){1'b0}}, 1'b1};
      diff_out = full[W-1:0];
      carry_out = full[W]; // see RULE_07
      half_carry_out = low[W/2];
      wrap_out = (a_in[W-1] != b_in[W-1]) && (full[W-1] != a_in[W-1]);
      zero_out = (full[W-1:0] == '0);
   end
endmodule // mcuix_sub

// ===== mcuix_exec.sv
// Purpose: executes a subset of 8-bit core instructions, one per cycle
// Assumes: data byte and program word are presented in the cycle of the request
// Notes: a taken skip holds busy one extra cycle as the dummy fetch
`timescale 1ns/100ps
// What this block does
// RULE_01 - bit set forces selected memory bit to one, flags untouched
// RULE_02 - inc_skip_zero increments memory byte, skips next when result is zero
// RULE_03 - inc_to_work_skip_null puts byte plus one in work, skips on zero
// RULE_04 - a taken skip adds one dummy cycle, making two cycles
// RULE_05 - skip_if_bit_set skips next when selected bit is one
// RULE_06 - minus_to_work: work minus byte into work, four flags updated
// RULE_07 - subtraction carry is zero when negative, one otherwise
// RULE_08 - minus_to_memory writes work minus byte to memory, four flags
// RULE_09 - immediate subtract: work minus constant into work, four flags
// RULE_10 - nibble_exchange swaps byte nibbles in memory, no flags
// RULE_11 - nibble_exchange_to_work puts swapped byte in work, memory unchanged
// RULE_12 - skip_if_null skips next when byte is zero, nothing modified
// RULE_13 - copy_then_skip_null copies byte to work, skips when zero
// RULE_14 - skip_if_bit_clear skips next when selected bit is zero
// RULE_15 - table_read_current_page: low byte to memory, high part to latch
// RULE_16 - table_read_last_page does the same from the last page
// RULE_17 - register exclusive-OR into work, only zero flag changes
// RULE_18 - exclusive_or_to_memory writes xor to memory, only zero flag
// RULE_19 - immediate exclusive-OR into work, only zero flag changes
// RULE_20 - non-skipping ops take one cycle; latch takes upper word bits
module mcuix_exec #(
   parameter int PADDR_W = mcuix_pkg::PADDR_W,
   parameter int PROG_W = mcuix_pkg::PROG_W
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic exec_valid_in,
   input wire logic [4:0] exec_op_in,
   input wire logic [2:0] exec_bit_in,
   input wire logic [7:0] exec_imm_in,
   input wire logic [7:0] mem_rdata_in,
   input wire logic [PADDR_W-1:0] current_pc_in,
   input wire logic [7:0] table_pointer_in,
   input wire logic [PROG_W-1:0] prog_rdata_in,
   output logic [PADDR_W-1:0] prog_addr_out,
   output logic mem_we_out,
   output logic [7:0] mem_wdata_out,
   output logic [7:0] work_out,
   output logic signed_wrap_flag_out,
   output logic zero_flag_out,
   output logic half_carry_flag_out,
   output logic carry_flag_out,
   output logic [PROG_W-9:0] table_high_latch_out,
   output logic skip_out,
   output logic busy_out,
   output logic done_out
);
   typedef enum logic {
      MCUIX_RUN,
      MCUIX_DUMMY
   } mcuix_state_type;

   mcuix_state_type state_q, state_d;
   logic [7:0] work_q, work_d;
   logic [7:0] mem_wdata_q, mem_wdata_d;
   logic mem_we_q, mem_we_d;
   logic [3:0] flags_q, flags_d;
   logic [PROG_W-9:0] tbl_hi_q, tbl_hi_d;
   logic [PADDR_W-1:0] prog_addr_q, prog_addr_d;
   logic skip_q, skip_d;
   logic busy_q, busy_d;
   logic done_q, done_d;

   logic [7:0] sub_b;
   logic [7:0] sub_diff;
   logic sub_c, sub_ac, sub_ov, sub_z;
   logic [7:0] inc_val;
   logic [7:0] swap_val;
   logic [7:0] xor_val;
   logic [7:0] bit_mask;
   logic sel_bit;
   logic do_skip;
   mcuix_pkg::mcuix_op_type op;

   mcuix_sub #(
      .W(mcuix_pkg::DATA_W)
   ) u_sub (
      .a_in(work_q),
      .b_in(sub_b),
      .diff_out(sub_diff),
      .carry_out(sub_c),
      .half_carry_out(sub_ac),
      .wrap_out(sub_ov),
      .zero_out(sub_z)
   );

   always_comb
   begin
      op = mcuix_pkg::mcuix_op_type'(exec_op_in);
      if (exec_op_in == mcuix_pkg::MCUIX_OP_XOR_IMM_CODE)
      begin
         op = mcuix_pkg::MCUIX_OP_NONE;
      end
      sub_b = (op == mcuix_pkg::MCUIX_OP_MINUS_IMM) ? exec_imm_in : mem_rdata_in;
      inc_val = mem_rdata_in + mcuix_pkg::BYTE_ONE;
      swap_val = {mem_rdata_in[mcuix_pkg::NIB_W-1:0], mem_rdata_in[mcuix_pkg::DATA_W-1:mcuix_pkg::NIB_W]};
      xor_val = work_q ^ ((exec_op_in == mcuix_pkg::MCUIX_OP_XOR_IMM_CODE) ? exec_imm_in : mem_rdata_in);
      bit_mask = mcuix_pkg::BYTE_ONE << exec_bit_in;
      sel_bit = mem_rdata_in[exec_bit_in];
   end

   always_comb
   begin
      state_d = state_q;
      work_d = work_q;
      mem_wdata_d = mem_wdata_q;
      mem_we_d = 1'b0;
      flags_d = flags_q;
      tbl_hi_d = tbl_hi_q;
      skip_d = 1'b0;
      busy_d = 1'b0;
      done_d = 1'b0;
      do_skip = 1'b0;
      case (state_q)
         MCUIX_RUN:
         begin
            if (exec_valid_in)
            begin
               done_d = 1'b1; // see RULE_20
               if (exec_op_in == mcuix_pkg::MCUIX_OP_XOR_IMM_CODE)
               begin
                  work_d = xor_val; // see RULE_19
                  flags_d[mcuix_pkg::FLAG_Z] = (xor_val == mcuix_pkg::BYTE_ZERO);
               end
               else
               begin
                  case (op)
                     mcuix_pkg::MCUIX_OP_BIT_SET:
                     begin
                        mem_wdata_d = mem_rdata_in | bit_mask; // see RULE_01
                        mem_we_d = 1'b1;
                     end
                     mcuix_pkg::MCUIX_OP_INC_SKIP_ZERO:
                     begin
                        mem_wdata_d = inc_val; // see RULE_02
                        mem_we_d = 1'b1;
                        do_skip = (inc_val == mcuix_pkg::BYTE_ZERO);
                     end
                     mcuix_pkg::MCUIX_OP_INC_TO_WORK_SKIP_NULL:
                     begin
                        work_d = inc_val; // see RULE_03
                        do_skip = (inc_val == mcuix_pkg::BYTE_ZERO);
                     end
                     mcuix_pkg::MCUIX_OP_SKIP_IF_BIT_SET:
                     begin
                        do_skip = sel_bit; // see RULE_05
                     end
                     mcuix_pkg::MCUIX_OP_MINUS_TO_WORK, mcuix_pkg::MCUIX_OP_MINUS_IMM:
                     begin
                        work_d = sub_diff; // see RULE_06 see RULE_09
                        flags_d[mcuix_pkg::FLAG_OV] = sub_ov;
                        flags_d[mcuix_pkg::FLAG_Z] = sub_z;
                        flags_d[mcuix_pkg::FLAG_AC] = sub_ac;
                        flags_d[mcuix_pkg::FLAG_C] = sub_c; // see RULE_07
                     end
                     mcuix_pkg::MCUIX_OP_MINUS_TO_MEMORY:
                     begin
                        mem_wdata_d = sub_diff; // see RULE_08
                        mem_we_d = 1'b1;
                        flags_d[mcuix_pkg::FLAG_OV] = sub_ov;
                        flags_d[mcuix_pkg::FLAG_Z] = sub_z;
                        flags_d[mcuix_pkg::FLAG_AC] = sub_ac;
                        flags_d[mcuix_pkg::FLAG_C] = sub_c;
                     end
                     mcuix_pkg::MCUIX_OP_NIBBLE_EXCHANGE:
                     begin
                        mem_wdata_d = swap_val; // see RULE_10
                        mem_we_d = 1'b1;
                     end
                     mcuix_pkg::MCUIX_OP_NIBBLE_EXCHANGE_TO_WORK:
                     begin
                        work_d = swap_val; // see RULE_11
                     end
                     mcuix_pkg::MCUIX_OP_SKIP_IF_NULL:
                     begin
                        do_skip = (mem_rdata_in == mcuix_pkg::BYTE_ZERO); // see RULE_12
                     end
                     mcuix_pkg::MCUIX_OP_COPY_THEN_SKIP_NULL:
                     begin
                        work_d = mem_rdata_in; // see RULE_13
                        do_skip = (mem_rdata_in == mcuix_pkg::BYTE_ZERO);
                     end
                     mcuix_pkg::MCUIX_OP_SKIP_IF_BIT_CLEAR:
                     begin
                        do_skip = !sel_bit; // see RULE_14
                     end
                     mcuix_pkg::MCUIX_OP_TABLE_READ_CURRENT_PAGE, mcuix_pkg::MCUIX_OP_TABLE_READ_LAST_PAGE:
                     begin
                        mem_wdata_d = prog_rdata_in[mcuix_pkg::DATA_W-1:0]; // see RULE_15 see RULE_16
                        mem_we_d = 1'b1;
                        tbl_hi_d = prog_rdata_in[PROG_W-1:mcuix_pkg::DATA_W]; // see RULE_20
                     end
                     mcuix_pkg::MCUIX_OP_XOR_TO_WORK:
                     begin
                        work_d = xor_val; // see RULE_17
                        flags_d[mcuix_pkg::FLAG_Z] = (xor_val == mcuix_pkg::BYTE_ZERO);
                     end
                     mcuix_pkg::MCUIX_OP_EXCLUSIVE_OR_TO_MEMORY:
                     begin
                        mem_wdata_d = xor_val; // see RULE_18
                        mem_we_d = 1'b1;
                        flags_d[mcuix_pkg::FLAG_Z] = (xor_val == mcuix_pkg::BYTE_ZERO);
                     end
                     default:
                     begin
                        done_d = 1'b1;
                     end
                  endcase
               end
               if (do_skip)
               begin
                  skip_d = 1'b1; // see RULE_04
                  busy_d = 1'b1;
                  state_d = MCUIX_DUMMY;
               end
            end
         end
         MCUIX_DUMMY:
         begin
            state_d = MCUIX_RUN; // see RULE_04
         end
         default:
         begin
            state_d = MCUIX_RUN;
         end
      endcase
   end

   // table read program address: current page keeps pc upper bits, last page forces them high
   always_comb
   begin
      prog_addr_d = {current_pc_in[PADDR_W-1:mcuix_pkg::DATA_W], table_pointer_in}; // see RULE_15
      if (op == mcuix_pkg::MCUIX_OP_TABLE_READ_LAST_PAGE)
      begin
         prog_addr_d = {{(PADDR_W-mcuix_pkg::DATA_W){1'b1}}, table_pointer_in}; // see RULE_16
      end
   end

   // sequencing state
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_q <= MCUIX_RUN;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // completion, skip and dummy-cycle pulses
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         skip_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         skip_q <= skip_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   // working register and status flags
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         work_q <= mcuix_pkg::ACC_RESET;
         flags_q <= mcuix_pkg::FLAGS_RESET;
      end
      else
      begin
         work_q <= work_d;
         flags_q <= flags_d;
      end
   end

   // data memory write port
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mem_wdata_q <= mcuix_pkg::BYTE_ZERO;
         mem_we_q <= 1'b0;
      end
      else
      begin
         mem_wdata_q <= mem_wdata_d;
         mem_we_q <= mem_we_d;
      end
   end

   // table high latch
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tbl_hi_q <= '0;
      end
      else
      begin
         tbl_hi_q <= tbl_hi_d;
      end
   end

   // program address for table reads
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         prog_addr_q <= '0;
      end
      else
      begin
         prog_addr_q <= prog_addr_d;
      end
   end

   always_comb
   begin
      prog_addr_out = prog_addr_q;
      mem_we_out = mem_we_q;
      mem_wdata_out = mem_wdata_q;
      work_out = work_q;
      signed_wrap_flag_out = flags_q[mcuix_pkg::FLAG_OV];
      zero_flag_out = flags_q[mcuix_pkg::FLAG_Z];
      half_carry_flag_out = flags_q[mcuix_pkg::FLAG_AC];
      carry_flag_out = flags_q[mcuix_pkg::FLAG_C];
      table_high_latch_out = tbl_hi_q;
      skip_out = skip_q;
      busy_out = busy_q;
      done_out = done_q;
   end
endmodule // mcuix_exec

// ===== mcuix_exec_sva.sv
// Purpose: port checker for the execute subset
// Assumes: one clock, async active-high reset
// Notes: bound from the bench top file
`timescale 1ns/100ps
module mcuix_exec_sva #(
   parameter int PADDR_W = 11,
   parameter int PROG_W = 14
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic exec_valid_in,
   input wire logic [4:0] exec_op_in,
   input wire logic [7:0] table_pointer_in,
   input wire logic [PADDR_W-1:0] prog_addr_out,
   input wire logic mem_we_out,
   input wire logic [7:0] work_out,
   input wire logic signed_wrap_flag_out,
   input wire logic zero_flag_out,
   input wire logic half_carry_flag_out,
   input wire logic carry_flag_out,
   input wire logic [PROG_W-9:0] table_high_latch_out,
   input wire logic skip_out,
   input wire logic busy_out,
   input wire logic done_out
);
   logic [3:0] flags;
   assign flags = {signed_wrap_flag_out, zero_flag_out, half_carry_flag_out, carry_flag_out};
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   sequence s_skip;
      skip_out;
   endsequence
   sequence s_dummy;
      busy_out ##1 !done_out;
   endsequence
   a_skip_dummy: assert property (s_skip |-> s_dummy) else $error("skip without dummy cycle");
   a_busy_skip: assert property (busy_out |-> skip_out) else $error("busy without skip");
   a_skip_done: assert property (skip_out |-> done_out) else $error("skip without done");
   a_write_done: assert property (mem_we_out |-> done_out) else $error("write without done");
   a_done_request: assert property (done_out |-> $past(exec_valid_in) && !$past(busy_out))
      else $error("done without accepted request");
   a_flags_hold: assert property (flags != $past(flags) |-> done_out) else $error("flags moved idle");
   a_work_hold: assert property (work_out != $past(work_out) |-> done_out) else $error("work moved idle");
   a_latch_hold: assert property (table_high_latch_out != $past(table_high_latch_out) |-> done_out)
      else $error("latch moved idle");
   a_last_page: assert property (exec_valid_in && !busy_out && exec_op_in == 5'h0e |=>
      prog_addr_out == {{(PADDR_W-8){1'b1}}, $past(table_pointer_in)}) else $error("last page address");
endmodule // mcuix_exec_sva

// ===== mcuix_exec_bench.sv
// Purpose: self-checking bench for the execute subset
// Assumes: stimulus at falling edge, outputs read at falling edge
// Notes: data byte and program word are driven directly
`timescale 1ns/100ps
module mcuix_exec_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic exec_valid_in = 1'b0;
   logic [4:0] exec_op_in = 5'h00;
   logic [2:0] exec_bit_in = 3'h0;
   logic [7:0] exec_imm_in = 8'h00, mem_rdata_in = 8'h00, table_pointer_in = 8'h77;
   logic [10:0] current_pc_in = 11'h500, prog_addr_out;
   logic [13:0] prog_rdata_in = 14'h0000;
   logic [7:0] mem_wdata_out, work_out;
   logic [5:0] table_high_latch_out;
   logic mem_we_out, signed_wrap_flag_out, zero_flag_out, half_carry_flag_out, carry_flag_out;
   logic skip_out, busy_out, done_out;
   logic [3:0] flags;
   int miscompares = 0;
   int comparisons = 0;
   assign flags = {signed_wrap_flag_out, zero_flag_out, half_carry_flag_out, carry_flag_out};
   mcuix_exec u_mcuix_exec (.clk_in, .rst_in, .exec_valid_in, .exec_op_in, .exec_bit_in, .exec_imm_in,
      .mem_rdata_in, .current_pc_in, .table_pointer_in, .prog_rdata_in, .prog_addr_out, .mem_we_out,
      .mem_wdata_out, .work_out, .signed_wrap_flag_out, .zero_flag_out, .half_carry_flag_out,
      .carry_flag_out, .table_high_latch_out, .skip_out, .busy_out, .done_out);
   always #5 clk_in = ~clk_in;
   task automatic report_and_stop();
      if (miscompares == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm, m,
      input logic sk, we, input logic [7:0] wd);
      exec_op_in = op;
      exec_bit_in = b;
      exec_imm_in = imm;
      mem_rdata_in = m;
      exec_valid_in = 1'b1;
      @(negedge clk_in);
      exec_valid_in = 1'b0;
      cmp_val({done_out, skip_out, busy_out, mem_we_out}, {1'b1, sk, sk, we});
      if (we)
         cmp_val(mem_wdata_out, wd);
      @(negedge clk_in);
   endtask
   task automatic load(input logic [7:0] w);
      run(5'h0b, 3'h0, 8'h00, w, w == 8'h00, 1'b0, 8'h00);
   endtask
   task automatic t_bit_set();
      logic [3:0] f;
      f = flags;
      for (int i = 0; i < 8; i++)
         run(5'h01, i[2:0], 8'h00, 8'h24, 1'b0, 1'b1, 8'h24 | (8'h01 << i));
      cmp_val(flags, f);
   endtask
   task automatic t_inc();
      run(5'h02, 3'h0, 8'h00, 8'h41, 1'b0, 1'b1, 8'h42);
      run(5'h02, 3'h0, 8'h00, 8'hff, 1'b1, 1'b1, 8'h00);
      run(5'h03, 3'h0, 8'h00, 8'h7f, 1'b0, 1'b0, 8'h00);
      cmp_val(work_out, 8'h80);
      run(5'h03, 3'h0, 8'h00, 8'hff, 1'b1, 1'b0, 8'h00);
      cmp_val(work_out, 8'h00);
   endtask
   task automatic t_refuse();
      exec_op_in = 5'h02;
      mem_rdata_in = 8'hff;
      exec_valid_in = 1'b1;
      @(negedge clk_in);
      exec_op_in = 5'h08;
      cmp_val({skip_out, busy_out}, 2'h3);
      @(negedge clk_in);
      exec_valid_in = 1'b0;
      cmp_val({done_out, mem_we_out}, 2'h0);
      @(negedge clk_in);
   endtask
   task automatic t_bits();
      for (int i = 0; i < 8; i++)
      begin
         run(5'h04, i[2:0], 8'h00, 8'h5a, 8'h5a >> i & 8'h01, 1'b0, 8'h00);
         run(5'h0c, i[2:0], 8'h00, 8'h5a, ~(8'h5a >> i) & 8'h01, 1'b0, 8'h00);
      end
   endtask
   task automatic t_sub();
      logic [7:0] wt [4] = '{8'h35, 8'h10, 8'h80, 8'h13};
      logic [7:0] mt [4] = '{8'h35, 8'h20, 8'h01, 8'h05};
      logic [7:0] w, m, d;
      logic [4:0] op;
      for (int k = 0; k < 12; k++)
      begin
         op = 5'(5 + k / 4);
         w = wt[k % 4];
         m = mt[k % 4];
         d = w - m;
         load(w);
         run(op, 3'h0, m, (op == 5'h07) ? 8'hc3 : m, 1'b0, op == 5'h06, d);
         cmp_val(work_out, (op == 5'h06) ? w : d);
         cmp_val(flags, {(w[7] != m[7]) && (d[7] != w[7]), d == 8'h00, w[3:0] >= m[3:0], w >= m});
      end
   endtask
   task automatic t_swap();
      logic [3:0] f;
      f = flags;
      run(5'h08, 3'h0, 8'h00, 8'h3c, 1'b0, 1'b1, 8'hc3);
      run(5'h09, 3'h0, 8'h00, 8'ha5, 1'b0, 1'b0, 8'h00);
      cmp_val(work_out, 8'h5a);
      cmp_val(flags, f);
   endtask
   task automatic t_zero();
      load(8'h44);
      run(5'h0a, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      run(5'h0a, 3'h0, 8'h00, 8'h01, 1'b0, 1'b0, 8'h00);
      cmp_val(work_out, 8'h44);
      run(5'h0b, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      cmp_val(work_out, 8'h00);
   endtask
   task automatic t_table();
      prog_rdata_in = 14'h3abc;
      run(5'h0d, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1, 8'hbc);
      cmp_val({prog_addr_out, table_high_latch_out}, {11'h577, 6'h3a});
      prog_rdata_in = 14'h2f01;
      run(5'h0e, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1, 8'h01);
      cmp_val({prog_addr_out, table_high_latch_out}, {11'h777, 6'h2f});
   endtask
   task automatic t_xor();
      logic [3:0] f;
      load(8'h0f);
      f = flags;
      run(5'h0f, 3'h0, 8'h00, 8'hf0, 1'b0, 1'b0, 8'h00);
      cmp_val({work_out, flags}, {8'hff, f[3], 1'b0, f[1:0]});
      run(5'h10, 3'h0, 8'h00, 8'h0f, 1'b0, 1'b1, 8'hf0);
      run(5'h11, 3'h0, 8'hff, 8'h00, 1'b0, 1'b0, 8'h00);
      cmp_val({work_out, flags}, {8'h00, f[3], 1'b1, f[1:0]});
   endtask
   initial
   begin
      #50000;
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      @(negedge clk_in);
      cmp_val({work_out, flags, done_out}, 13'h0000);
      t_bit_set();
      t_inc();
      t_refuse();
      t_bits();
      t_sub();
      t_swap();
      t_zero();
      t_table();
      t_xor();
      report_and_stop();
   end
endmodule // mcuix_exec_bench
bind mcuix_exec mcuix_exec_sva #(.PADDR_W(PADDR_W), .PROG_W(PROG_W)) u_mcuix_exec_sva (.clk_in, .rst_in,
   .exec_valid_in, .exec_op_in, .table_pointer_in, .prog_addr_out, .mem_we_out, .work_out,
   .signed_wrap_flag_out, .zero_flag_out, .half_carry_flag_out, .carry_flag_out, .table_high_latch_out,
   .skip_out, .busy_out, .done_out);
